// ### shared/sfac_pkg.sv
package sfac_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam logic [15:0] ADDR_RX_CTRL  = 16'h705B;
  localparam logic [15:0] ADDR_FIFO_CTL = 16'h705C;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h7060;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h7061;
  localparam int          RX_IRQ_FLAG   = 7;
  localparam int          RX_IRQ_CLR    = 6;
  localparam int          RX_IRQ_EN     = 5;
  localparam int          RX_LVL_LSB    = 0;
  localparam int          RX_CNT_LSB    = 8;
  localparam int          ABD_DONE      = 15;
  localparam int          AUTOBAUD_DONE_CLEAR       = 14;
  localparam int          ABD_ALIGN     = 13;
  localparam int          DLY_LSB       = 0;
  localparam logic [4:0]  RX_LVL_RESET  = 5'h1F;
  localparam logic [7:0]  DLY_RESET     = 8'h00;
  localparam logic [7:0]  CHAR_UPPER_A  = 8'h41;
  localparam logic [7:0]  CHAR_LOWER_A  = 8'h61;
  localparam int          ST_RX_LEVEL   = 0;
  localparam int          ST_AUTOBAUD   = 1;
  localparam int          ST_W          = 2;
  typedef enum logic [1:0] {SFAC_IDLE, SFAC_DELAY, SFAC_LOAD} sfac_tx_state_t;
endpackage : sfac_pkg

// ### shared/sfac_tx_if.sv
`timescale 1ns/1ps
interface sfac_tx_if;
  logic       baud_tick;
  logic       shift_idle;
  logic [7:0] delay;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       load;
  modport pacer (input baud_tick, input shift_idle, input delay, input fifo_valid, output fifo_pop, output load);
  modport top   (output baud_tick, output shift_idle, output delay, output fifo_valid, input fifo_pop, input load);
endinterface : sfac_tx_if

// ### hw/sfac_baud_div.sv
`timescale 1ns/1ps
module sfac_baud_div #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_reg;
  wire              wrap = (cnt_reg >= divisor);

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      tick    <= wrap;
    end
endmodule : sfac_baud_div

// ### hw/sfac_tx_pacer.sv
`timescale 1ns/1ps
module sfac_tx_pacer (
  input  wire logic clk,
  input  wire logic sys_rst,
  sfac_tx_if.pacer  tx
);
  import sfac_pkg::*;
  sfac_tx_state_t state_reg;
  logic [8:0]     wait_reg;

  // Pop only once shifter is idle, so no extra hidden level exists
  wire start   = (state_reg == SFAC_IDLE) && tx.fifo_valid && tx.shift_idle;
  wire expired = (wait_reg == '0);
  assign tx.fifo_pop = (state_reg == SFAC_LOAD);
  assign tx.load     = (state_reg == SFAC_LOAD);

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg <= SFAC_IDLE;
      wait_reg  <= '0;
    end
    else
    begin
      unique case (state_reg)
        SFAC_IDLE:
        begin
          if (start)
          begin
            wait_reg  <= {1'b0, tx.delay};
            state_reg <= SFAC_DELAY;
          end
        end
        SFAC_DELAY:
        begin
          if (expired)
            state_reg <= SFAC_LOAD;
          else if (tx.baud_tick)
            wait_reg <= wait_reg - 9'h001;
        end
        SFAC_LOAD:
          state_reg <= SFAC_IDLE;
      endcase
    end
endmodule : sfac_tx_pacer

// ### hw/sfac_top.sv
`timescale 1ns/1ps
module sfac_top #(
  parameter int DIV_W = 16
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [sfac_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [sfac_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic                     bus_wr,
  input  wire logic                     bus_rd,
  output logic      [sfac_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic [DIV_W-1:0]         baud_divisor,
  input  wire logic [4:0]               rx_fifo_count,
  input  wire logic                     rx_char_valid,
  input  wire logic [7:0]               rx_char,
  input  wire logic                     tx_fifo_valid,
  output logic                          tx_fifo_pop,
  input  wire logic                     tx_shift_idle,
  output logic                          tx_shift_load,
  output logic                          autobaud_align_enable,
  output logic                          rx_irq,
  output logic                          irq
);
  import sfac_pkg::*;

  logic             rx_fifo_irq_flag_reg;
  logic             rx_fifo_irq_enable_reg;
  logic [4:0]       rx_fifo_level_reg;
  logic             autobaud_done_reg;
  logic             align_reg;
  logic [7:0]       tx_transfer_delay_reg;
  logic [ST_W-1:0]  irq_stat_reg;
  logic [ST_W-1:0]  irq_mask_reg;
  logic             level_prev_reg;
  logic             abd_prev_reg;
  logic [DATA_W-1:0] rdata_next;
  logic             baud_tick;

  wire sel_rx   = (bus_addr == ADDR_RX_CTRL);
  wire sel_fct  = (bus_addr == ADDR_FIFO_CTL);
  wire sel_st   = (bus_addr == ADDR_IRQ_STAT);
  wire sel_mk   = (bus_addr == ADDR_IRQ_MASK);
  wire wr_rx    = bus_wr && sel_rx;
  wire wr_fct   = bus_wr && sel_fct;
  wire wr_st    = bus_wr && sel_st;
  wire wr_mk    = bus_wr && sel_mk;

  wire rx_level_match = (rx_fifo_count >= rx_fifo_level_reg);
  wire clr_rx_irq     = wr_rx && bus_wdata[RX_IRQ_CLR];
  wire clr_abd        = wr_fct && bus_wdata[AUTOBAUD_DONE_CLEAR];
  // Character check is only meaningful while alignment is armed
  wire abd_hit        = align_reg && rx_char_valid &&
                        ((rx_char == CHAR_UPPER_A) || (rx_char == CHAR_LOWER_A));

  wire [ST_W-1:0] stat_events;
  assign stat_events[ST_RX_LEVEL] = rx_level_match && !level_prev_reg;
  assign stat_events[ST_AUTOBAUD] = abd_hit && !abd_prev_reg;
  wire [ST_W-1:0] stat_clear = wr_st ? bus_wdata[ST_W-1:0] : '0;

  // Clear bits always read zero; reserved 15..13 of RX control and 12..8 of FIFO control read zero
  wire [DATA_W-1:0] rx_view  = {3'h0, rx_fifo_count, rx_fifo_irq_flag_reg, 1'b0,
                                rx_fifo_irq_enable_reg, rx_fifo_level_reg};
  wire [DATA_W-1:0] fct_view = {autobaud_done_reg, 1'b0, align_reg, 5'h00,
                                tx_transfer_delay_reg};

  always_comb
  begin
    rdata_next = '0;
    if (bus_rd)
    begin
      if (sel_rx)
        rdata_next = rx_view;
      else if (sel_fct)
        rdata_next = fct_view;
      else if (sel_st)
        rdata_next = {{(DATA_W-ST_W){1'b0}}, irq_stat_reg};
      else if (sel_mk)
        rdata_next = {{(DATA_W-ST_W){1'b0}}, irq_mask_reg};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      bus_rdata <= '0;
    else
      bus_rdata <= rdata_next;

  // Flag is hardware-set only; set wins over a same-cycle clear
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      rx_fifo_irq_flag_reg <= 1'b0;
    else if (rx_level_match)
      rx_fifo_irq_flag_reg <= 1'b1;
    else if (clr_rx_irq)
      rx_fifo_irq_flag_reg <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      rx_fifo_irq_enable_reg <= 1'b0;
      rx_fifo_level_reg      <= RX_LVL_RESET;
    end
    else if (wr_rx)
    begin
      rx_fifo_irq_enable_reg <= bus_wdata[RX_IRQ_EN];
      rx_fifo_level_reg      <= bus_wdata[RX_LVL_LSB +: 5];
    end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      autobaud_done_reg <= 1'b0;
    else if (abd_hit)
      autobaud_done_reg <= 1'b1;
    else if (clr_abd)
      autobaud_done_reg <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      align_reg             <= 1'b0;
      tx_transfer_delay_reg <= DLY_RESET;
    end
    else if (wr_fct)
    begin
      align_reg             <= bus_wdata[ABD_ALIGN];
      tx_transfer_delay_reg <= bus_wdata[DLY_LSB +: 8];
    end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      level_prev_reg <= 1'b0;
      abd_prev_reg   <= 1'b0;
      irq_stat_reg   <= '0;
      irq_mask_reg   <= '0;
    end
    else
    begin
      level_prev_reg <= rx_level_match;
      abd_prev_reg   <= abd_hit;
      irq_stat_reg   <= stat_events | (irq_stat_reg & ~stat_clear);
      if (wr_mk)
        irq_mask_reg <= bus_wdata[ST_W-1:0];
    end

  assign rx_irq                = rx_fifo_irq_flag_reg && rx_fifo_irq_enable_reg;
  assign irq                   = |(irq_stat_reg & irq_mask_reg);
  assign autobaud_align_enable = align_reg;

  sfac_tx_if txi ();
  assign txi.baud_tick  = baud_tick;
  assign txi.shift_idle = tx_shift_idle;
  assign txi.delay      = tx_transfer_delay_reg;
  assign txi.fifo_valid = tx_fifo_valid;
  assign tx_fifo_pop    = txi.fifo_pop;
  assign tx_shift_load  = txi.load;

  sfac_baud_div #(.DIV_W(DIV_W)) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .divisor (baud_divisor),
    .tick    (baud_tick)
  );

  sfac_tx_pacer u_pacer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tx      (txi.pacer)
  );
endmodule : sfac_top

// ### tb/sfac_top_asserts.sv
`timescale 1ns/1ps
module sfac_top_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic [4:0]  rx_fifo_count,
  input wire logic        tx_fifo_pop,
  input wire logic        tx_shift_idle,
  input wire logic        tx_shift_load,
  input wire logic        autobaud_align_enable,
  input wire logic        rx_irq
);
  import sfac_pkg::*;
  logic rd_q;
  logic rx_q;
  logic ct_q;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      rd_q <= 1'b0;
      rx_q <= 1'b0;
      ct_q <= 1'b0;
    end
    else
    begin
      rd_q <= bus_rd;
      rx_q <= bus_rd && bus_addr == ADDR_RX_CTRL;
      ct_q <= bus_rd && bus_addr == ADDR_FIFO_CTL;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence load_pulse;
    tx_shift_load && tx_fifo_pop;
  endsequence
  load_pop_a: assert property (tx_shift_load == tx_fifo_pop) else $error("load without pop");
  load_idle_a: assert property (tx_shift_load |-> tx_shift_idle) else $error("load while shifting");
  load_once_a: assert property (load_pulse |=> !tx_shift_load) else $error("load too long");
  rd_zero_a: assert property (!rd_q |-> bus_rdata == 16'h0000) else $error("rdata not idle");
  rx_clr_a: assert property (rx_q |-> !bus_rdata[6]) else $error("rx clear reads one");
  ct_rsv_a: assert property (ct_q |-> !bus_rdata[14] && bus_rdata[12:8] == 5'h00) else $error("reserved bits set");
  rx_cnt_a: assert property (rx_q |-> bus_rdata[12:8] == $past(rx_fifo_count)) else $error("count");
  rx_irq_a: assert property (rx_q |-> (bus_rdata[7] & bus_rdata[5]) == $past(rx_irq)) else $error("irq");
  align_rd_a: assert property (ct_q |-> bus_rdata[13] == $past(autobaud_align_enable)) else $error("align");
endmodule : sfac_top_asserts
bind sfac_top sfac_top_asserts u_asserts (.*);

// ### tb/sfac_line_model.sv
`timescale 1ns/1ps
module sfac_line_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic go,
  input  wire logic tx_shift_load,
  output logic      tx_fifo_valid,
  output logic      tx_shift_idle,
  output int        gmin,
  output int        gmax,
  output int        n_loads
);
  int left;
  int busy;
  int wait_cyc;
  assign tx_fifo_valid = left > 0;
  // Shifter reports idle only once its last bit is out
  assign tx_shift_idle = busy == 0;
  // Non-blocking updates keep the levels stable at the edge where the design samples them
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      left     <= 0;
      busy     <= 0;
      wait_cyc <= 0;
      gmin     <= 999;
      gmax     <= 0;
      n_loads  <= 0;
    end
    else if (tx_shift_load)
    begin
      left     <= left - 1;
      busy     <= 10;
      n_loads  <= n_loads + 1;
      gmin     <= wait_cyc < gmin ? wait_cyc : gmin;
      gmax     <= wait_cyc > gmax ? wait_cyc : gmax;
      wait_cyc <= 0;
    end
    else
    begin
      if (go)
        left <= 2;
      if (busy > 0)
        busy <= busy - 1;
      else if (tx_fifo_valid)
        wait_cyc <= wait_cyc + 1;
    end
endmodule : sfac_line_model

// ### tb/sfac_top_tb.sv
`timescale 1ns/1ps
module sfac_top_tb;
  import sfac_pkg::*;
  logic clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, rx_char_valid = 0, go = 0;
  logic [15:0] bus_addr = 0, bus_wdata = 0, bus_rdata;
  logic [4:0]  rx_fifo_count = 0;
  logic [7:0]  rx_char = 0;
  logic        tx_fifo_valid, tx_fifo_pop, tx_shift_idle, tx_shift_load, align, rx_irq, irq;
  int          mismatches = 0, n_checks = 0, gmin, gmax, n_loads;
  always #50 clk = ~clk;
  sfac_top u_dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .baud_divisor(16'h0003), .rx_fifo_count(rx_fifo_count),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_fifo_valid(tx_fifo_valid), .tx_fifo_pop(tx_fifo_pop),
    .tx_shift_idle(tx_shift_idle), .tx_shift_load(tx_shift_load), .autobaud_align_enable(align),
    .rx_irq(rx_irq), .irq(irq));
  sfac_line_model u_line (.clk(clk), .sys_rst(sys_rst), .go(go), .tx_shift_load(tx_shift_load),
    .tx_fifo_valid(tx_fifo_valid), .tx_shift_idle(tx_shift_idle), .gmin(gmin), .gmax(gmax), .n_loads(n_loads));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk("rdata", e, bus_rdata);
  endtask : rd
  task send(input logic [7:0] c);
    @(posedge clk);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge clk);
    rx_char_valid <= 1'b0;
  endtask : send
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_RX_CTRL, 16'h001F);
    rd(ADDR_FIFO_CTL, 16'h0000);
    wr(ADDR_FIFO_CTL, 16'hFFFF);
    rd(ADDR_FIFO_CTL, 16'h20FF);
    chk("align", 16'h0001, {15'h0, align});
    wr(ADDR_FIFO_CTL, 16'h2002);
    $display("test registers done");
    send(CHAR_UPPER_A);
    rd(ADDR_FIFO_CTL, 16'hA002);
    wr(ADDR_FIFO_CTL, 16'h6002);
    rd(ADDR_FIFO_CTL, 16'h2002);
    send(8'h42);
    rd(ADDR_FIFO_CTL, 16'h2002);
    send(CHAR_LOWER_A);
    wr(ADDR_FIFO_CTL, 16'h2002);
    rd(ADDR_FIFO_CTL, 16'hA002);
    wr(ADDR_FIFO_CTL, 16'h6002);
    $display("test autobaud done");
    wr(ADDR_RX_CTRL, 16'h0023);
    rx_fifo_count <= 5'h02;
    rd(ADDR_RX_CTRL, 16'h0223);
    chk("rx_irq", 16'h0000, {15'h0, rx_irq});
    rx_fifo_count <= 5'h03;
    rd(ADDR_RX_CTRL, 16'h03A3);
    chk("rx_irq", 16'h0001, {15'h0, rx_irq});
    wr(ADDR_IRQ_MASK, 16'h0001);
    chk("irq", 16'h0001, {15'h0, irq});
    wr(ADDR_RX_CTRL, 16'h0043);
    rd(ADDR_RX_CTRL, 16'h0383);
    chk("rx_irq", 16'h0000, {15'h0, rx_irq});
    rx_fifo_count <= 5'h10;
    rd(ADDR_RX_CTRL, 16'h1083);
    wr(ADDR_RX_CTRL, 16'h0051);
    rx_fifo_count <= 5'h00;
    wr(ADDR_RX_CTRL, 16'h0043);
    rd(ADDR_RX_CTRL, 16'h0003);
    rd(ADDR_IRQ_STAT, 16'h0003);
    rd(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0003);
    chk("irq", 16'h0000, {15'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0000);
    rd(16'h7070, 16'h0000);
    $display("test rx level done");
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 300 && n_loads < 2; i++)
      @(posedge clk);
    chk("loads", 16'h0002, n_loads[15:0]);
    chk("gap_min", 16'h0001, {15'h0, gmin >= 6});
    chk("gap_max", 16'h0001, {15'h0, gmax <= 11});
    $display("test tx delay done");
    results();
  end
endmodule : sfac_top_tb
